// ### core/esr_fifo_mem.sv
// fifo storage array with registered read data
`timescale 1ns/1ns
`default_nettype none
module esr_fifo_mem #(
	parameter int unsigned W     = 9,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	// clock
	input  wire logic          ref_clk,
	// write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// read side
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);
	logic [W-1:0] mem_q [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule
`default_nettype wire

// ### core/esr_fifo_service.sv
// fifo with DMA request and programmed-I/O service interrupt generation
`timescale 1ns/1ns
`default_nettype none
module esr_fifo_service #(
	parameter int unsigned DEPTH     = esr_pkg::FIFO_DEPTH,
	parameter int unsigned BURST_MAX = esr_pkg::DMA_BURST_MAX,
	parameter int unsigned IDLE_CYC  = esr_pkg::DMA_IDLE_CYC
) (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        srst,
	// host bus pins
	input  wire logic [esr_pkg::ADDR_W-1:0]  io_addr,
	input  wire logic [esr_pkg::DATA_W-1:0]  io_wdata,
	input  wire logic                        io_read_strobe_n,
	input  wire logic                        io_write_strobe_n,
	input  wire logic                        port_dma_ack_n,
	input  wire logic                        terminal_count,
	output logic      [esr_pkg::DATA_W-1:0]  io_rdata,
	output logic                             io_rdata_oe,
	// service requests
	output logic                             port_dma_request,
	output logic                             port_interrupt_out,
	// control
	input  wire logic                        direction,
	input  wire logic                        dma_enable_bit,
	input  wire logic                        test_mode,
	input  wire logic [3:0]                  threshold_field,
	input  wire logic                        mask_wr,
	input  wire logic                        mask_wr_val,
	output logic                             service_intr_mask,
	// status
	output logic      [$clog2(DEPTH):0]      fifo_count,
	output logic                             fifo_empty,
	output logic                             fifo_full,
	output logic      [$clog2(DEPTH):0]      write_service_level,
	output logic      [$clog2(DEPTH):0]      read_service_level,
	output logic      [$clog2(DEPTH):0]      fifo_depth,
	// peripheral fill side (reverse)
	input  wire logic                        periph_in_valid,
	input  wire logic [esr_pkg::DATA_W-1:0]  periph_in_data,
	output logic                             periph_in_ready,
	// peripheral drain side (forward), bit 8 marks a command byte
	output logic                             periph_out_valid,
	output logic      [esr_pkg::DATA_W:0]    periph_out_data,
	input  wire logic                        periph_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = AW + 1;
	localparam int unsigned BW = $clog2(BURST_MAX + 1);
	localparam int unsigned IW = $clog2(IDLE_CYC + 1);
	localparam int unsigned MW = esr_pkg::DATA_W + 1;
	localparam int unsigned SW = esr_pkg::ADDR_W + esr_pkg::DATA_W;
	localparam logic [CW-1:0] DEPTH_C   = CW'(DEPTH);
	localparam logic [CW-1:0] THR_CAP_C = CW'(esr_pkg::THR_CAP);
	localparam logic [BW-1:0] BURST_C   = BW'(BURST_MAX - 1);
	localparam logic [IW-1:0] IDLE_C    = IW'(IDLE_CYC - 1);

	// pin synchronisers: {tc, ack_n, write_n, read_n} and {addr, data}
	logic [3:0]    ctl_s1_q, ctl_s2_q, ctl_s3_q;
	logic [SW-1:0] bus_s1_q, bus_s2_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctl_s1_q <= esr_pkg::CTL_SYNC_RST;
			ctl_s2_q <= esr_pkg::CTL_SYNC_RST;
			ctl_s3_q <= esr_pkg::CTL_SYNC_RST;
		end else begin
			ctl_s1_q <= {terminal_count, port_dma_ack_n, io_write_strobe_n, io_read_strobe_n};
			ctl_s2_q <= ctl_s1_q;
			ctl_s3_q <= ctl_s2_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		bus_s1_q <= {io_addr, io_wdata};
		bus_s2_q <= bus_s1_q;
	end

	wire                              rd_fall  = ctl_s3_q[0] & ~ctl_s2_q[0];
	wire                              wr_fall  = ctl_s3_q[1] & ~ctl_s2_q[1];
	wire                              ack_fall = ctl_s3_q[2] & ~ctl_s2_q[2];
	wire                              ack_act  = ~ctl_s2_q[2];
	wire                              rd_act   = ~ctl_s2_q[0];
	wire                              tc_s     = ctl_s2_q[3];
	wire [esr_pkg::ADDR_W-1:0]        addr_s   = bus_s2_q[SW-1:esr_pkg::DATA_W];
	wire [esr_pkg::DATA_W-1:0]        data_s   = bus_s2_q[esr_pkg::DATA_W-1:0];

	// port decode; a DMA cycle needs no valid address
	wire hit_data = addr_s == esr_pkg::DATA_FIFO_OFS;
	wire hit_addr = addr_s == esr_pkg::ADDR_FIFO_OFS;
	wire rev_path = direction | test_mode;
	wire fwd_path = ~direction | test_mode;
	wire rd_hit   = ack_act | hit_data;
	wire wr_hit   = ack_act | hit_data | (hit_addr & ~test_mode);
	wire cmd_wr   = ~ack_act & ~hit_data & hit_addr;

	// occupancy and pointers
	logic [CW-1:0] count_q;
	logic [AW-1:0] wr_ptr_q, rd_ptr_q;
	wire           empty = count_q == '0;
	wire           full  = count_q == DEPTH_C;

	// two-entry drain buffer toward the peripheral
	logic [1:0]    buf_cnt_q;
	logic [MW-1:0] buf0_q, buf1_q;
	logic          drain_pend_q, host_pend_q;
	wire [MW-1:0]  mem_rdata;
	wire           buf_room = (buf_cnt_q == 2'd0) | ((buf_cnt_q == 2'd1) & ~drain_pend_q);
	wire           buf_in   = drain_pend_q;
	wire           buf_out  = periph_out_valid & periph_out_ready;

	wire periph_push = periph_in_valid & direction & ~test_mode & ~full;
	wire host_push   = wr_fall & wr_hit & fwd_path & ~full;
	wire push        = periph_push | host_push;
	wire host_pop    = rd_fall & rd_hit & rev_path & ~empty;
	wire drain_pop   = ~direction & ~test_mode & ~empty & buf_room;
	wire pop         = host_pop | drain_pop;
	wire [MW-1:0] push_data = host_push ? {cmd_wr, data_s} : {1'b0, periph_in_data};

	wire [CW-1:0] count_d = count_q + CW'(push) - CW'(pop);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_q  <= '0;
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			count_q  <= count_d;
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
		end
	end

	esr_fifo_mem #(
		.W     (MW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.ref_clk (ref_clk),
		.wr_en   (push),
		.wr_addr (wr_ptr_q),
		.wr_data (push_data),
		.rd_en   (pop),
		.rd_addr (rd_ptr_q),
		.rd_data (mem_rdata)
	);

	// host read data and bus drive
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			host_pend_q  <= 1'b0;
			drain_pend_q <= 1'b0;
			io_rdata     <= '0;
			io_rdata_oe  <= 1'b0;
		end else begin
			host_pend_q  <= host_pop;
			drain_pend_q <= drain_pop;
			io_rdata_oe  <= rd_act & rd_hit & rev_path;
			if (host_pend_q) begin
				io_rdata <= mem_rdata[esr_pkg::DATA_W-1:0];
			end
		end
	end

	// drain buffer: a stalled peripheral holds words here and the fifo backs up
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			buf_cnt_q <= 2'd0;
			buf0_q    <= '0;
			buf1_q    <= '0;
		end else begin
			if (buf_in & buf_out) begin
				if (buf_cnt_q == 2'd1) begin
					buf0_q <= mem_rdata;
				end else begin
					buf0_q <= buf1_q;
					buf1_q <= mem_rdata;
				end
			end else if (buf_in) begin
				buf_cnt_q <= buf_cnt_q + 2'd1;
				if (buf_cnt_q == 2'd0) begin
					buf0_q <= mem_rdata;
				end else begin
					buf1_q <= mem_rdata;
				end
			end else if (buf_out) begin
				buf_cnt_q <= buf_cnt_q - 2'd1;
				buf0_q    <= buf1_q;
			end
		end
	end

	// threshold and service levels
	wire [CW-1:0] thr_raw = CW'(threshold_field) + CW'(1);
	wire [CW-1:0] thr_eff = (thr_raw > THR_CAP_C) ? THR_CAP_C : thr_raw;
	wire [CW-1:0] svc_lvl = DEPTH_C - thr_eff;
	wire          rev_svc = count_q >= svc_lvl;
	wire          fwd_svc = count_q <= thr_eff;

	// mask and terminal count
	logic mask_q, tc_irq_q, irq_q;
	wire  tc_event = tc_s & ack_act & dma_enable_bit & ~mask_q;
	wire  mask_clr = mask_wr & ~mask_wr_val;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mask_q   <= esr_pkg::MASK_RST;
			tc_irq_q <= 1'b0;
		end else begin
			if (tc_event) begin
				mask_q <= 1'b1;
			end else if (mask_wr) begin
				mask_q <= mask_wr_val;
			end
			if (tc_event) begin
				tc_irq_q <= 1'b1;
			end else if (mask_clr) begin
				tc_irq_q <= 1'b0;
			end
		end
	end

	// level condition re-evaluated every cycle, so clearing the mask fires at once
	wire pio_irq = ~mask_q & ~dma_enable_bit & ~test_mode & (direction ? rev_svc : fwd_svc);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= tc_irq_q | pio_irq;
		end
	end

	// DMA request
	logic          dreq_q, last_hold_q, hold_q;
	logic [BW-1:0] burst_q;
	logic [IW-1:0] idle_q;
	wire           dma_ok    = dma_enable_bit & ~mask_q & ~test_mode;
	wire           want      = dma_ok & (direction ? ~empty : ~full);
	wire           dma_edge  = ack_fall | (rd_fall & ack_act);
	wire           last_set  = dma_edge & direction & (count_q == CW'(1));
	wire           burst_hit = ack_fall & dreq_q & (burst_q == BURST_C);
	wire           tc_drop   = tc_s & ack_act;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			last_hold_q <= 1'b0;
		end else if (last_set) begin
			last_hold_q <= 1'b1;
		end else if (~ack_act) begin
			last_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			burst_q <= '0;
			hold_q  <= 1'b0;
			idle_q  <= '0;
		end else if (hold_q) begin
			burst_q <= '0;
			if (ack_act) begin
				idle_q <= '0;
			end else if (idle_q == IDLE_C) begin
				hold_q <= 1'b0;
			end else begin
				idle_q <= idle_q + IW'(1);
			end
		end else if (burst_hit) begin
			hold_q  <= 1'b1;
			idle_q  <= '0;
			burst_q <= '0;
		end else if (~dreq_q) begin
			burst_q <= '0;
		end else if (ack_fall) begin
			burst_q <= burst_q + BW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dreq_q <= 1'b0;
		end else begin
			dreq_q <= want & ~hold_q & ~burst_hit & ~last_set & ~last_hold_q & ~tc_drop;
		end
	end

	// outputs
	assign port_dma_request    = dreq_q;
	assign port_interrupt_out  = irq_q;
	assign service_intr_mask   = mask_q;
	assign fifo_count          = count_q;
	assign fifo_empty          = empty;
	assign fifo_full           = full;
	assign write_service_level = svc_lvl;
	assign read_service_level  = svc_lvl;
	assign fifo_depth          = DEPTH_C;
	assign periph_in_ready     = direction & ~test_mode & ~full;
	assign periph_out_valid    = buf_cnt_q != 2'd0;
	assign periph_out_data     = buf0_q;
endmodule
`default_nettype wire

// ### core/esr_pkg.sv
// shared constants for the parallel-port fifo service-request block
// Function
// - reverse DMA: request asserted whenever fifo holds a byte and DMA is enabled.
// - request drops when fifo empties, or terminal count arrives with acknowledge active.
// - last byte: request released on acknowledge going active, else on read strobe.
// - after an empty-caused drop, request returns as soon as one byte is present.
// - after a terminal-count drop, request returns only once software clears the mask.
// - programmed I/O decodes data/test fifo at 400H and address fifo at 000H.
// - in programmed I/O mode service is requested on the interrupt output.
// - a threshold of sixteen behaves exactly like a threshold of fifteen.
// - reverse, mask clear: interrupt while byte count >= sixteen minus threshold.
// - forward, mask clear: interrupt while byte count <= threshold.
// - test mode exposes read and write service levels and fifo depth.
// - mask set blocks DMA and service interrupts; clearing it raises pending ones at once.
// - effective threshold 1..16 is the four-bit field plus one.
// - terminal count raises the interrupt and sets the mask, stopping DMA.
// - request held at most 32 DMA cycles, then low until acknowledge idle 350 ns.
package esr_pkg;
	localparam int unsigned FIFO_DEPTH     = 16;
	localparam int unsigned DATA_W         = 8;
	localparam int unsigned CMD_BIT        = 8;
	localparam int unsigned ADDR_W         = 11;
	localparam logic [10:0] DATA_FIFO_OFS  = 11'h400;
	localparam logic [10:0] ADDR_FIFO_OFS  = 11'h000;
	localparam int unsigned THR_CAP        = 15;
	localparam logic        MASK_RST       = 1'b1;
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned DMA_IDLE_NS    = 350;
	localparam int unsigned DMA_IDLE_CYC   = (DMA_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DMA_BURST_MAX  = 32;
	localparam logic [3:0]  CTL_SYNC_RST   = 4'h7;
endpackage

// ### verif/ecp_fifo_service_request_test.sv
// self-checking bench of the fifo service-request block
`timescale 1ns/1ns
`default_nettype none
module ecp_fifo_service_request_test;
	logic        ref_clk = 1'b0, srst = 1'b1, direction = 1'b1, dma_enable_bit = 1'b0;
	logic        test_mode = 1'b0, mask_wr = 1'b0, mask_wr_val = 1'b0, dma_go = 1'b0;
	logic        periph_in_valid = 1'b0, periph_out_ready = 1'b0;
	logic [3:0]  threshold_field = 4'h0, thr;
	logic [7:0]  periph_in_data = 8'h00, tc_at = 8'h0c, io_wdata, io_rdata, v;
	logic [10:0] io_addr;
	logic        io_read_strobe_n, io_write_strobe_n, port_dma_ack_n, terminal_count;
	logic        io_rdata_oe, port_dma_request, port_interrupt_out, service_intr_mask;
	logic        fifo_empty, fifo_full, periph_in_ready, periph_out_valid;
	logic [4:0]  fifo_count, write_service_level, read_service_level, fifo_depth;
	logic [8:0]  periph_out_data, exp_q[$];
	int          error_cnt = 0, comparisons = 0, cycles = 0, i, k;
	esr_fifo_service #(.BURST_MAX(4), .IDLE_CYC(3)) u_esr_fifo_service (.*);
	esr_host_model u_esr_host_model (.*);
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	function logic [4:0] lvl(input logic [3:0] f);
		return 5'h10 - ((f == 4'hf) ? 5'h0f : {1'b0, f} + 5'h01);
	endfunction
	task chk(input string s, input logic [8:0] e, input logic [8:0] g);
		comparisons++;
		if (e !== g) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task give_verdict();
		if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task setmask(input logic b);
		mask_wr = 1'b1;
		mask_wr_val = b;
		@(negedge ref_clk);
		mask_wr = 1'b0;
	endtask
	task push(input logic [7:0] b);
		periph_in_data = b;
		periph_in_valid = 1'b1;
		@(negedge ref_clk);
		periph_in_valid = 1'b0;
		periph_in_data = ~b;
		@(negedge ref_clk);
	endtask
	initial begin
		void'($urandom(32'h3fdc5cd1));
		repeat (10) @(negedge ref_clk);
		srst = 1'b0;
		@(negedge ref_clk);
		chk("mask", 9'h1, service_intr_mask);
		chk("empty", 9'h1, fifo_empty);
		chk("depth", 9'h10, fifo_depth);
		for (i = 0; i < 16; i++) begin
			threshold_field = i[3:0];
			@(negedge ref_clk);
			chk("wlvl", lvl(i[3:0]), write_service_level);
			chk("rlvl", lvl(i[3:0]), read_service_level);
		end
		thr = 4'($urandom);
		threshold_field = thr;
		setmask(1'b0);
		for (i = 1; i <= 16; i++) begin
			exp_q.push_back({1'b0, 8'($urandom)});
			push(exp_q[i-1][7:0]);
			chk("rirq", i >= lvl(thr), port_interrupt_out);
		end
		chk("inrdy", 9'h0, periph_in_ready);
		while (exp_q.size() > 0) begin
			u_esr_host_model.rd(v);
			chk("rd", exp_q.pop_front(), {1'b0, v});
		end
		direction = 1'b0;
		for (i = 1; i <= 20; i++) begin
			v = 8'($urandom);
			if (i <= 18) exp_q.push_back({i == 1, v});
			u_esr_host_model.wr((i == 1) ? 11'h000 : 11'h400, v);
			chk("wirq", ((i > 18) ? 16 : (i > 2) ? i - 2 : 0) <= 16 - lvl(thr),
				port_interrupt_out);
		end
		for (k = 0; k < 400 && exp_q.size() > 0; k++) begin
			periph_out_ready = 1'($urandom);
			if (periph_out_ready && periph_out_valid)
				chk("out", exp_q.pop_front(), periph_out_data);
			@(negedge ref_clk);
		end
		periph_out_ready = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("left", 9'h0, 9'(exp_q.size()));
		chk("oval", 9'h0, periph_out_valid);
		// test mode: address fifo refused, data fifo reads back, peripheral and interrupt idle
		test_mode = 1'b1;
		u_esr_host_model.wr(11'h000, 8'h5a);
		for (i = 0; i < 3; i++) begin
			exp_q.push_back({1'b0, 8'($urandom)});
			u_esr_host_model.wr(11'h400, exp_q[i][7:0]);
		end
		chk("tcnt", 9'h3, 9'(fifo_count));
		chk("tirq", 9'h0, port_interrupt_out);
		chk("toval", 9'h0, periph_out_valid);
		while (exp_q.size() > 0) begin
			u_esr_host_model.rd(v);
			chk("trd", exp_q.pop_front(), {1'b0, v});
		end
		test_mode = 1'b0;
		direction = 1'b1;
		dma_enable_bit = 1'b1;
		dma_go = 1'b1;
		for (i = 0; i < 12; i++) begin
			exp_q.push_back({1'b0, 8'($urandom)});
			push(exp_q[i][7:0]);
			if (i == 7) begin
				for (k = 0; k < 400 && u_esr_host_model.q.size() < 8; k++) @(negedge ref_clk);
				chk("req0", 9'h0, port_dma_request);
			end
		end
		for (k = 0; k < 400 && service_intr_mask !== 1'b1; k++) @(negedge ref_clk);
		chk("tcmask", 9'h1, service_intr_mask);
		repeat (3) @(negedge ref_clk);
		chk("tcirq", 9'h1, port_interrupt_out);
		exp_q.push_back({1'b0, 8'($urandom)});
		push(exp_q[12][7:0]);
		repeat (20) @(negedge ref_clk);
		chk("tcreq", 9'h0, port_dma_request);
		setmask(1'b0);
		for (k = 0; k < 400 && u_esr_host_model.q.size() < 13; k++) @(negedge ref_clk);
		for (i = 0; i < 13; i++)
			chk("dma", exp_q[i], {1'b0, u_esr_host_model.q[i]});
		// second reset in mid-run with DMA still enabled
		srst = 1'b1;
		repeat (3) @(negedge ref_clk);
		srst = 1'b0;
		@(negedge ref_clk);
		chk("smask", 9'h1, service_intr_mask);
		chk("sreq", 9'h0, port_dma_request);
		chk("sirq", 9'h0, port_interrupt_out);
		chk("sempty", 9'h1, fifo_empty);
		give_verdict();
	end
endmodule
bind esr_fifo_service esr_checker #(.BURST_MAX(BURST_MAX)) u_esr_checker (.ref_clk, .srst,
	.direction, .dma_enable_bit, .test_mode, .threshold_field, .port_dma_ack_n,
	.io_read_strobe_n, .io_addr, .io_rdata_oe,
	.service_intr_mask, .port_dma_request, .port_interrupt_out, .fifo_empty, .fifo_full,
	.fifo_count, .write_service_level, .read_service_level, .fifo_depth);
`default_nettype wire

// ### verif/esr_checker.sv
// assertions on the fifo service-request ports
`timescale 1ns/1ns
`default_nettype none
module esr_checker #(
	parameter int unsigned BURST_MAX = 32
) (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       srst,
	// control
	input wire logic       direction,
	input wire logic       dma_enable_bit,
	input wire logic       test_mode,
	input wire logic [3:0] threshold_field,
	input wire logic       port_dma_ack_n,
	input wire logic       io_read_strobe_n,
	input wire logic [10:0] io_addr,
	// outputs
	input wire logic       service_intr_mask,
	input wire logic       port_dma_request,
	input wire logic       port_interrupt_out,
	input wire logic       io_rdata_oe,
	input wire logic       fifo_empty,
	input wire logic       fifo_full,
	input wire logic [4:0] fifo_count,
	input wire logic [4:0] write_service_level,
	input wire logic [4:0] read_service_level,
	input wire logic [4:0] fifo_depth
);
	wire logic pio = !dma_enable_bit && !service_intr_mask && !test_mode;
	wire logic rcond = pio && direction && fifo_count >= read_service_level;
	wire logic wcond = pio && !direction && fifo_count <= 5'h10 - write_service_level;
	logic       ack_q;
	logic [5:0] burst_q;
	// acknowledge falls counted while the request stays up
	always_ff @(posedge ref_clk) begin
		ack_q <= port_dma_ack_n;
		if (srst || !port_dma_request)
			burst_q <= 6'h00;
		else if (ack_q && !port_dma_ack_n)
			burst_q <= burst_q + 6'h01;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_mask_blk; $past(service_intr_mask) || $past(test_mode) |-> !port_dma_request; endproperty
	a_mask_blk: assert property (p_mask_blk) else $error("request while masked");
	property p_req_en; port_dma_request |-> $past(dma_enable_bit); endproperty
	a_req_en: assert property (p_req_en) else $error("request without dma enable");
	property p_req_data; port_dma_request && direction && $past(direction) |-> $past(fifo_count) != 5'h00; endproperty
	a_req_data: assert property (p_req_data) else $error("request on empty fifo");
	property p_rirq; $past(rcond) |-> port_interrupt_out; endproperty
	a_rirq: assert property (p_rirq) else $error("reverse interrupt missing");
	property p_wirq; $past(wcond) |-> port_interrupt_out; endproperty
	a_wirq: assert property (p_wirq) else $error("forward interrupt missing");
	property p_lvl; write_service_level == 5'h10 - ((threshold_field == 4'hf) ? 5'h0f
		: threshold_field + 5'h01) && read_service_level == write_service_level; endproperty
	a_lvl: assert property (p_lvl) else $error("service level wrong");
	property p_flags; fifo_empty == (fifo_count == 5'h00) && fifo_full == (fifo_count == 5'h10); endproperty
	a_flags: assert property (p_flags) else $error("flags disagree with count");
	property p_step; fifo_count <= $past(fifo_count) + 5'h01 && $past(fifo_count) <= fifo_count + 5'h01; endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_depth; fifo_depth == 5'h10; endproperty
	a_depth: assert property (p_depth) else $error("depth wrong");
	// pins reach the drive enable through two sync stages and one register
	property p_oe; io_rdata_oe == (!$past(io_read_strobe_n, 3) && (!$past(port_dma_ack_n, 3)
		|| $past(io_addr, 3) == 11'h400) && ($past(direction) || $past(test_mode))); endproperty
	a_oe: assert property (p_oe) else $error("read drive enable wrong");
	property p_burst; burst_q <= BURST_MAX; endproperty
	a_burst: assert property (p_burst) else $error("request burst too long");
endmodule
`default_nettype wire

// ### verif/esr_host_model.sv
// host cpu and dma controller model on the bus pins
`timescale 1ns/1ns
`default_nettype none
module esr_host_model (
	// clock and device side
	input  wire logic       ref_clk,
	input  wire logic       port_dma_request,
	input  wire logic [7:0] io_rdata,
	input  wire logic       dma_go,
	input  wire logic [7:0] tc_at,
	// bus pins
	output logic     [10:0] io_addr,
	output logic     [7:0]  io_wdata,
	output logic            io_read_strobe_n,
	output logic            io_write_strobe_n,
	output logic            port_dma_ack_n,
	output logic            terminal_count
);
	logic [7:0] q[$];
	logic [7:0] n = 8'h00;
	logic [7:0] dv;
	initial begin
		io_addr = 11'h400;
		io_wdata = 8'h00;
		{io_read_strobe_n, io_write_strobe_n, port_dma_ack_n} = 3'h7;
		terminal_count = 1'b0;
	end
	// strobe low six cycles, then high four
	task cyc(input logic rd, output logic [7:0] v);
		if (rd) io_read_strobe_n = 1'b0;
		else io_write_strobe_n = 1'b0;
		repeat (6) @(negedge ref_clk);
		v = io_rdata;
		{io_read_strobe_n, io_write_strobe_n, port_dma_ack_n} = 3'h7;
		terminal_count = 1'b0;
		// a released bus does not keep its last value
		io_wdata = ~io_wdata;
		io_addr = ~io_addr;
		repeat (4) @(negedge ref_clk);
	endtask
	task wr(input logic [10:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		repeat (3) @(negedge ref_clk);
		cyc(1'b0, dv);
	endtask
	task rd(output logic [7:0] v);
		io_addr = 11'h400;
		repeat (3) @(negedge ref_clk);
		cyc(1'b1, v);
	endtask
	always @(negedge ref_clk) if (dma_go && port_dma_request) begin
		n = n + 8'h01;
		port_dma_ack_n = 1'b0;
		terminal_count = (n == tc_at);
		cyc(1'b1, dv);
		q.push_back(dv);
	end
endmodule
`default_nettype wire
